// ==== verilog/buck_seq_regs.svh ====
// Timing constants and fixed counts for the buck start-up sequencer.
`ifndef BUCK_SEQ_REGS_SVH
`define BUCK_SEQ_REGS_SVH
`define CLK_PERIOD_NS 10
`define INIT_DELAY_US 6800
`define SAMPLE_MAX_US 3400
`define SS_RAMP_US 13600
`define SS_STEPS 64
`define INIT_DELAY_CYC ((`INIT_DELAY_US * 1000) / `CLK_PERIOD_NS)
`define SAMPLE_MAX_CYC ((`SAMPLE_MAX_US * 1000) / `CLK_PERIOD_NS)
`define SS_STEP_CYC (((`SS_RAMP_US * 1000) / `CLK_PERIOD_NS) / `SS_STEPS)
`define SS_INIT_CYC 64
`define DUMMY_SS_COUNT 2
`define SETPOINT_W 8
`endif

// ==== verilog/buck_seq_pkg.sv ====
// Types shared by the buck start-up sequencer files.
package buck_seq_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_DELAY = 3'b001,
    ST_SAMPLE = 3'b011,
    ST_SS_INIT = 3'b010,
    ST_RAMP = 3'b110,
    ST_RUN = 3'b111,
    ST_HICCUP = 3'b101
  } seq_state_t;
endpackage

// ==== verilog/setpoint_sampler.sv ====
// Overcurrent set-point sample-and-hold counter.
`timescale 1ns/1ps
`include "buck_seq_regs.svh"
module setpoint_sampler (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic dac_below,
  output logic done,
  output logic [`SETPOINT_W-1:0] setpoint
);
  logic [`SETPOINT_W-1:0] cnt_reg, cnt_next;
  logic [31:0] tick_reg, tick_next;
  logic busy_reg, busy_next, done_reg, done_next;
  localparam logic [31:0] STEP = 32'(`SAMPLE_MAX_CYC / 256);
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = tick_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = '0;
      tick_next = '0;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      // Counter ramps the DAC until it reaches the pin voltage; higher settings take longer.
      if (!dac_below || cnt_reg == {`SETPOINT_W{1'b1}}) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else if (tick_reg >= STEP - 32'h1) begin
        tick_next = '0;
        cnt_next = cnt_reg + 1'b1;
      end else begin
        tick_next = tick_reg + 32'h1;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end
  assign done = done_reg;
  assign setpoint = cnt_reg;
endmodule

// ==== verilog/shoot_guard.sv ====
// Adaptive dead-time guard for the two gate drives.
`timescale 1ns/1ps
module shoot_guard (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic pwm_high,
  input wire logic high_gate_sense,
  input wire logic switch_node_high,
  input wire logic low_gate_sense,
  output logic high_on,
  output logic low_on
);
  logic hi_reg, hi_next, lo_reg, lo_next;
  always_comb begin
    hi_next = 1'b0;
    lo_next = 1'b0;
    if (enable) begin
      // High side only once the low gate reads off; low side only once the high side and node have fallen.
      hi_next = pwm_high && !lo_reg && !low_gate_sense; // RQ13 RQ15
      lo_next = !pwm_high && !hi_reg && !high_gate_sense && !switch_node_high; // RQ12 RQ15
    end
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hi_reg <= 1'b0;
      lo_reg <= 1'b0;
    end else begin
      hi_reg <= hi_next;
      lo_reg <= lo_next;
    end
  end
  assign high_on = hi_reg;
  assign low_on = lo_reg;
  a_no_overlap: assert property (@(posedge ref_clk) disable iff (rst) !(hi_reg && lo_reg)) // RQ15
    else $error("both gates on");
endmodule

// ==== verilog/buck_startup_sequencer.sv ====
// Start-up, shutdown and hiccup sequencer for a synchronous buck controller.
`timescale 1ns/1ps
`include "buck_seq_regs.svh"
//Behaviour
//[RQ1] Enable low: shutdown, gates low, re-arm
//[RQ2] Enable release restarts full initialization
//[RQ3] Held-low enable postpones initialization
//[RQ4] Supply-good starts initialization and sampling
//[RQ5] Timing starts above threshold, fixed delay
//[RQ6] Delay: low gate off, sense source on
//[RQ7] Sample lasts zero to maximum time
//[RQ8] Set-point held in counter while powered
//[RQ9] Soft-start launches when sampling completes
//[RQ10] Overcurrent: two dummy soft-starts, then real
//[RQ11] Shutdown disables compensation drive, pull-up stays
//[RQ12] High-side off seen via gate and node
//[RQ13] Low-side off seen via its gate
//[RQ14] External pull-down sinks full pin current
//[RQ15] Never both transistors on together
//[RQ16] Reference ramps in 64 equal steps
//[RQ17] Retries reuse the stored set-point
module buck_startup_sequencer
  import buck_seq_pkg::*;
#(
  parameter int INIT_DELAY = `INIT_DELAY_CYC,
  parameter int SS_STEP = `SS_STEP_CYC
) (
  // Clock and supply-good reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Comparators and fault input.
  input wire logic bias_good,
  input wire logic enable_above,
  input wire logic dac_below,
  input wire logic overcurrent_trip,
  input wire logic pwm_high,
  // Gate and switch-node senses.
  input wire logic high_gate_sense,
  input wire logic switch_node_high,
  input wire logic low_gate_sense,
  // Drives and status.
  output logic high_side_drive,
  output logic low_side_drive,
  output logic trip_sense_current,
  output logic comp_drive_en,
  output logic osc_run,
  output logic [5:0] ss_level,
  output logic [`SETPOINT_W-1:0] overcurrent_guard,
  output buck_seq_pkg::seq_state_t seq_state
);
  import buck_seq_pkg::*;
  seq_state_t st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [5:0] lvl_reg, lvl_next;
  logic [1:0] dummy_reg, dummy_next;
  logic sense_reg, sense_next, comp_reg, comp_next, osc_reg, osc_next, sample_start;
  logic hi_on, lo_on, smp_done;
  logic [`SETPOINT_W-1:0] setpoint, sp_reg;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    lvl_next = lvl_reg;
    dummy_next = dummy_reg;
    sample_start = 1'b0;
    case (st_reg)
      ST_OFF: begin
        cnt_next = '0;
        lvl_next = '0;
        dummy_next = '0;
        // Initialization waits for supply good and an enable above threshold.
        if (bias_good && enable_above) begin // RQ2 RQ3 RQ4 RQ5
          st_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (cnt_reg >= 32'(INIT_DELAY) - 32'h1) begin // RQ5
          cnt_next = '0;
          sample_start = 1'b1; // RQ4
          st_next = ST_SAMPLE;
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      ST_SAMPLE: begin
        if (smp_done) begin // RQ7 RQ9
          cnt_next = '0;
          st_next = ST_SS_INIT;
        end
      end
      ST_SS_INIT: begin
        if (cnt_reg >= 32'(`SS_INIT_CYC) - 32'h1) begin
          cnt_next = '0;
          st_next = ST_RAMP;
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      ST_RAMP: begin
        if (cnt_reg >= 32'(SS_STEP) - 32'h1) begin
          cnt_next = '0;
          lvl_next = lvl_reg + 6'h1; // RQ16
          if (lvl_reg == 6'h3f) begin
            lvl_next = lvl_reg;
            st_next = ST_RUN;
          end
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
        if (overcurrent_trip) begin
          cnt_next = '0;
          lvl_next = '0;
          st_next = ST_HICCUP;
        end
      end
      ST_RUN: begin
        if (overcurrent_trip) begin // RQ10
          cnt_next = '0;
          lvl_next = '0;
          st_next = ST_HICCUP;
        end
      end
      ST_HICCUP: begin
        // Each dummy time-out is one full ramp period with gates off; no new sample follows.
        if (cnt_reg >= 32'(SS_STEP) * 32'd64 - 32'h1) begin // RQ10 RQ17
          cnt_next = '0;
          if (dummy_reg == 2'(`DUMMY_SS_COUNT - 1)) begin
            dummy_next = '0;
            st_next = ST_SS_INIT;
          end else begin
            dummy_next = dummy_reg + 2'h1;
          end
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      default: st_next = ST_OFF;
    endcase
    if (!enable_above || !bias_good) begin // RQ1
      st_next = ST_OFF;
    end
    sense_next = (st_next == ST_DELAY) || (st_next == ST_SAMPLE); // RQ6
    comp_next = (st_next == ST_RAMP) || (st_next == ST_RUN); // RQ11
    osc_next = (st_next != ST_OFF); // RQ1
  end

  setpoint_sampler u_sampler (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(sample_start),
    .dac_below(dac_below),
    .done(smp_done),
    .setpoint(setpoint)
  );

  shoot_guard u_guard (
    .ref_clk(ref_clk),
    .rst(rst),
    // The guard's own flip-flops are the pin drives, so its interlock sees exactly what the transistors see.
    // Gates drop on the same edge as the compensation drive; none are on during delay or sampling.
    .enable(comp_next), // RQ1 RQ6
    .pwm_high(pwm_high),
    .high_gate_sense(high_gate_sense),
    .switch_node_high(switch_node_high),
    .low_gate_sense(low_gate_sense),
    .high_on(hi_on),
    .low_on(lo_on)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_reg <= ST_OFF;
      cnt_reg <= '0;
      lvl_reg <= '0;
      dummy_reg <= '0;
      sense_reg <= 1'b0;
      comp_reg <= 1'b0;
      osc_reg <= 1'b0;
      sp_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      lvl_reg <= lvl_next;
      dummy_reg <= dummy_next;
      sense_reg <= sense_next;
      comp_reg <= comp_next;
      osc_reg <= osc_next;
      if (smp_done) begin
        sp_reg <= setpoint; // RQ8
      end
    end
  end

  assign high_side_drive = hi_on; // RQ15
  assign low_side_drive = lo_on; // RQ15
  assign trip_sense_current = sense_reg;
  assign comp_drive_en = comp_reg;
  assign osc_run = osc_reg;
  assign ss_level = lvl_reg;
  assign overcurrent_guard = sp_reg;
  assign seq_state = st_reg;

  a_shutdown_gates: assert property (@(posedge ref_clk) disable iff (rst)
    !enable_above |=> (!high_side_drive && !low_side_drive && !osc_run)) // RQ1
    else $error("gates not low in shutdown");
  a_shutdown_comp: assert property (@(posedge ref_clk) disable iff (rst)
    !enable_above |=> !comp_drive_en) // RQ11
    else $error("comp drive on in shutdown");
  a_held_low_wait: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_OFF && !enable_above) |=> st_reg == ST_OFF) // RQ3
    else $error("init started with enable low");
  a_init_start: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_OFF && bias_good && enable_above) |=> st_reg == ST_DELAY) // RQ2
    else $error("init not started");
  a_delay_sense: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_DELAY) |-> (trip_sense_current && !low_side_drive)) // RQ6
    else $error("sense source off in delay");
  a_delay_sample: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_DELAY && $past(st_reg) == ST_OFF) |-> ##1 (st_reg == ST_DELAY)) // RQ5
    else $error("delay too short");
  a_sample_ss: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_SAMPLE && smp_done && enable_above && bias_good) |=> st_reg == ST_SS_INIT) // RQ9
    else $error("soft-start not launched");
  a_hold_set: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_HICCUP) |=> $stable(overcurrent_guard)) // RQ8 RQ17
    else $error("set-point changed on retry");
  a_trip_hiccup: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_RUN && overcurrent_trip && enable_above && bias_good) |=> (st_reg == ST_HICCUP && ss_level == 6'h0)) // RQ10
    else $error("trip not handled");
  a_ramp_step: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_RAMP && $past(st_reg) == ST_RAMP) |-> (ss_level - $past(ss_level)) <= 6'h1) // RQ16
    else $error("ramp step too large");
  a_gates_disabled: assert property (@(posedge ref_clk) disable iff (rst)
    !comp_drive_en |-> (!high_side_drive && !low_side_drive)) // RQ1 RQ6
    else $error("gate on while drive disabled");
  a_high_interlock: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(high_side_drive) |-> ($past(!low_gate_sense) && $past(!low_side_drive))) // RQ13 RQ15
    else $error("high side on before low side off");
  a_low_interlock: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(low_side_drive) |-> $past(!high_gate_sense && !switch_node_high && !high_side_drive)) // RQ12 RQ15
    else $error("low side on before high side off");
  a_retry_no_sample: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_HICCUP) |=> (st_reg != ST_SAMPLE)) // RQ17
    else $error("retry took a new sample");
  a_osc_stopped: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_OFF) |-> !osc_run) // RQ1
    else $error("oscillator running in shutdown");
  a_sense_off_run: assert property (@(posedge ref_clk) disable iff (rst)
    comp_drive_en |-> !trip_sense_current) // RQ6
    else $error("sense source on while regulating");
  a_ramp_from_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (st_reg == ST_SS_INIT) |-> (ss_level == 6'h0)) // RQ16
    else $error("ramp not re-armed");
  c_retry_restart: cover property (@(posedge ref_clk) st_reg == ST_HICCUP ##1 st_reg == ST_SS_INIT);
  c_reach_run: cover property (@(posedge ref_clk) st_reg == ST_RUN);
  c_hiccup: cover property (@(posedge ref_clk) st_reg == ST_HICCUP && dummy_reg == 2'h1);
  c_shutdown: cover property (@(posedge ref_clk) st_reg == ST_RAMP ##1 st_reg == ST_OFF);
endmodule

// ==== verification/fet_model.sv ====
// Behavioural power transistors and enable-pin pull-down on the far side.
`timescale 1ns/1ps
module fet_model (
  // Clock, gate drives and pull-down request.
  input wire logic ref_clk,
  input wire logic high_side_drive,
  input wire logic low_side_drive,
  input wire logic pull_down,
  // Sense levels back to the sequencer.
  output logic high_gate_sense,
  output logic switch_node_high,
  output logic low_gate_sense,
  output logic enable_above
);
  int hi_cnt = 0;
  int lo_cnt = 0;
  int en_cnt = 5;
  // Gates discharge over a random number of cycles, so turn-off is seen late.
  always @(posedge ref_clk) begin
    hi_cnt <= high_side_drive ? 1 + $urandom_range(0, 2) : (hi_cnt > 0 ? hi_cnt - 1 : 0);
    lo_cnt <= low_side_drive ? 1 + $urandom_range(0, 2) : (lo_cnt > 0 ? lo_cnt - 1 : 0);
    // The pull-down sinks the whole pin current; after release the pin charges slowly.
    en_cnt <= pull_down ? 5 : (en_cnt > 0 ? en_cnt - 1 : 0);
  end
  assign high_gate_sense = (hi_cnt != 0);
  assign switch_node_high = (hi_cnt != 0);
  assign low_gate_sense = (lo_cnt != 0);
  assign enable_above = (en_cnt == 0);
endmodule

// ==== verification/tb_top.sv ====
// Self-checking bench for the buck start-up sequencer.
`timescale 1ns/1ps
`include "buck_seq_regs.svh"
module tb_top;
  import buck_seq_pkg::*;
  localparam int INIT_DELAY = 20;
  localparam int SS_STEP = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic bias_good = 1'b0;
  logic pull_down = 1'b1;
  logic sample_below = 1'b1;
  logic overcurrent_trip = 1'b0;
  logic pwm_high = 1'b0;
  logic enable_above, high_gate_sense, switch_node_high, low_gate_sense;
  logic high_side_drive, low_side_drive, trip_sense_current, comp_drive_en, osc_run;
  logic hd_prev = 1'b0, ld_prev = 1'b0, hs_prev = 1'b0, sw_prev = 1'b0, ls_prev = 1'b0;
  logic [5:0] ss_level;
  logic [`SETPOINT_W-1:0] overcurrent_guard, held_point;
  seq_state_t seq_state;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int rises = 0;
  int n;

  buck_startup_sequencer #(.INIT_DELAY(INIT_DELAY), .SS_STEP(SS_STEP)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .bias_good(bias_good), .enable_above(enable_above),
    .dac_below(sample_below), .overcurrent_trip(overcurrent_trip), .pwm_high(pwm_high),
    .high_gate_sense(high_gate_sense), .switch_node_high(switch_node_high),
    .low_gate_sense(low_gate_sense), .high_side_drive(high_side_drive),
    .low_side_drive(low_side_drive), .trip_sense_current(trip_sense_current),
    .comp_drive_en(comp_drive_en), .osc_run(osc_run), .ss_level(ss_level),
    .overcurrent_guard(overcurrent_guard), .seq_state(seq_state));

  fet_model u_fet (
    .ref_clk(ref_clk), .high_side_drive(high_side_drive), .low_side_drive(low_side_drive),
    .pull_down(pull_down), .high_gate_sense(high_gate_sense), .switch_node_high(switch_node_high),
    .low_gate_sense(low_gate_sense), .enable_above(enable_above));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Waits at most limit edges for a state; n returns the edges waited.
  task automatic wait_state(input seq_state_t s, input int limit);
    n = 0;
    while (seq_state !== s && n < limit) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  always @(posedge ref_clk) begin
    if ($urandom_range(0, 3) == 0) begin
      pwm_high <= ~pwm_high;
    end
  end

  // Gate overlap and dead-time watch; the sense seen one edge earlier fed the decision.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      end_sim;
    end
    if (!rst) begin
      check(high_side_drive & low_side_drive, 1'b0);
      if (high_side_drive && !hd_prev) begin
        rises++;
        check(ls_prev, 1'b0);
      end
      if (low_side_drive && !ld_prev) begin
        check(hs_prev | sw_prev, 1'b0);
      end
    end
    hd_prev = high_side_drive;
    ld_prev = low_side_drive;
    hs_prev = high_gate_sense;
    sw_prev = switch_node_high;
    ls_prev = low_gate_sense;
  end

  initial begin
    int r;
    r = $urandom(51101);
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    bias_good <= 1'b1;
    #1;
    check(seq_state, ST_OFF);
    check({high_side_drive, low_side_drive, osc_run, comp_drive_en, trip_sense_current}, 0);
    repeat (30) @(posedge ref_clk);
    #1;
    check(seq_state, ST_OFF);
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk);
      pull_down <= 1'b0;
      sample_below <= (p != 0);
      #1;
      wait_state(ST_DELAY, 20);
      check(seq_state, ST_DELAY);
      check({trip_sense_current, low_side_drive, osc_run}, 3'b101);
      wait_state(ST_SAMPLE, 40);
      check(n, INIT_DELAY);
      if (p != 0) begin
        r = $urandom_range(1, 3000);
        repeat (r) @(posedge ref_clk);
        sample_below <= 1'b0;
        #1;
      end
      wait_state(ST_SS_INIT, 3000);
      check(seq_state, ST_SS_INIT);
      held_point = overcurrent_guard;
      if (p == 0) begin
        check(overcurrent_guard, 0);
      end
      wait_state(ST_RAMP, 80);
      check(n, 64);
      check(comp_drive_en, 1'b1);
      wait_state(ST_RUN, 300);
      check(n, 64 * SS_STEP);
      check(ss_level, 6'h3f);
      repeat (50) @(posedge ref_clk);
      overcurrent_trip <= 1'b1;
      @(posedge ref_clk);
      overcurrent_trip <= 1'b0;
      #1;
      wait_state(ST_HICCUP, 3);
      check(seq_state, ST_HICCUP);
      wait_state(ST_SS_INIT, 600);
      check(n, 2 * 64 * SS_STEP);
      check(overcurrent_guard, held_point);
      wait_state(ST_RUN, 400);
      check(seq_state, ST_RUN);
      @(posedge ref_clk);
      pull_down <= 1'b1;
      #1;
      wait_state(ST_OFF, 4);
      check(n, 2);
      @(posedge ref_clk);
      #1;
      check({high_side_drive, low_side_drive, osc_run, comp_drive_en}, 0);
      check(ss_level, 0);
    end
    // Supply loss in mid-delay returns the sequencer to off at once.
    @(posedge ref_clk);
    pull_down <= 1'b0;
    #1;
    wait_state(ST_DELAY, 20);
    @(posedge ref_clk);
    bias_good <= 1'b0;
    #1;
    wait_state(ST_OFF, 3);
    check(n, 1);
    check(rises > 0, 1'b1);
    end_sim;
  end
endmodule
